// file: src/pwrg_guard.sv
// Write-protect gate and protected low-power settings for the power control block.
`timescale 1ns/1ps

module pwrg_guard
   import pwrg_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire logic              alt_variant,
   input  wire pwrg_req_t         req,
   output logic [DATA_W-1:0]      rdata,
   output logic [NUM_GROUPS-1:0]  group_write_enable,
   output logic                   group_write_strobe,
   output logic [1:0]             group_write_id,
   output logic [DATA_W-1:0]      group_write_data,
   output pwrg_mode_t             power_mode,
   output pwrg_clk_t              return_clock,
   output logic                   return_clock_switch_enable,
   output logic                   sub_power_control
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic pwrg_mode_t decode_mode(input logic [2:0] code, input logic alt);
      pwrg_mode_t m;
      m = '0;
      if (alt) begin
         m.middle_1a   = (code == MODE_MIDDLE_1A);
         m.middle_1b   = (code == MODE_MIDDLE_1B);
         m.low_speed_1 = (code == MODE_LOW_SPEED_1);
         m.low_speed_2 = (code == MODE_LOW_SPEED_2);
      end else begin
         m.high_speed  = (code == MODE_HIGH_SPEED);
         m.middle_1a   = (code == MODE_MIDDLE_1A);
      end
      m.illegal = ~(m.high_speed | m.middle_1a | m.middle_1b | m.low_speed_1 | m.low_speed_2);
      return m;
   endfunction

   function automatic pwrg_clk_t decode_clock(input logic [2:0] code);
      pwrg_clk_t c;
      c = '0;
      c.slow_internal = (code == CLK_SLOW_INTERNAL);
      c.fast_internal = (code == CLK_FAST_INTERNAL);
      c.main_osc      = (code == CLK_MAIN_OSC);
      c.illegal       = ~(c.slow_internal | c.fast_internal | c.main_osc);
      return c;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [NUM_GROUPS-1:0] unlock_r;
   logic [NUM_GROUPS-1:0] unlock_nxt;
   logic [2:0]            mode_code_r;
   logic [2:0]            mode_code_nxt;
   logic                  sub_power_r;
   logic                  sub_power_nxt;
   logic [2:0]            clock_code_r;
   logic [2:0]            clock_code_nxt;
   logic                  clock_switch_r;
   logic                  clock_switch_nxt;
   logic                  blocked_r;
   logic                  blocked_nxt;
   logic                  alt_seen_r;
   logic                  alt_seen_nxt;
   logic [DATA_W-1:0]     rdata_r;
   logic [DATA_W-1:0]     rdata_nxt;
   logic                  gw_strobe_r;
   logic                  gw_strobe_nxt;
   logic [1:0]            gw_id_r;
   logic [1:0]            gw_id_nxt;
   logic [DATA_W-1:0]     gw_data_r;
   logic [DATA_W-1:0]     gw_data_nxt;
   pwrg_mode_t            mode_dec_r;
   pwrg_mode_t            mode_dec_nxt;
   pwrg_clk_t             clock_dec_r;
   pwrg_clk_t             clock_dec_nxt;

   logic                  sys_open;
   logic                  wr_opc;
   logic                  wr_sub;
   logic                  wr_rck;
   logic                  wr_grp;
   logic                  grp_open;
   logic                  blocked_event;
   logic [1:0]            req_group;

   // ----------------------------------------------------------------
   // Write decode and protection gate
   // ----------------------------------------------------------------
   assign sys_open  = unlock_r[POS_SYSTEM_GROUP_UNLOCK];
   assign req_group = req.wdata[DATA_W-1:DATA_W-2];
   assign grp_open  = unlock_r[req_group];

   always_comb begin
      wr_opc = 1'b0;
      wr_sub = 1'b0;
      wr_rck = 1'b0;
      wr_grp = 1'b0;
      if (req.wr && req.addr == OFS_OPERATING_POWER_CONTROL) begin
         wr_opc = 1'b1;
      end else if (req.wr && req.addr == OFS_SUB_POWER_CONTROL) begin
         wr_sub = 1'b1;
      end else if (req.wr && req.addr == OFS_SLEEP_RETURN_CLOCK_SELECT) begin
         wr_rck = 1'b1;
      end else if (req.wr && req.addr == OFS_GROUP_WRITE_REQUEST) begin
         wr_grp = 1'b1;
      end
   end

   // A write aimed at a locked group counts as blocked; the status flag tells software why nothing changed.
   assign blocked_event = ((wr_opc | wr_sub | wr_rck) & ~sys_open) | (wr_grp & ~grp_open);

   // ----------------------------------------------------------------
   // Register next values
   // ----------------------------------------------------------------
   always_comb begin
      unlock_nxt       = unlock_r;
      mode_code_nxt    = mode_code_r;
      sub_power_nxt    = sub_power_r;
      clock_code_nxt   = clock_code_r;
      clock_switch_nxt = clock_switch_r;
      blocked_nxt      = blocked_r;
      alt_seen_nxt     = alt_variant;
      gw_strobe_nxt    = 1'b0;
      gw_id_nxt        = gw_id_r;
      gw_data_nxt      = gw_data_r;
      if (req.wr && req.addr == OFS_WRITE_PROTECT_CONTROL) begin
         unlock_nxt = req.wdata[NUM_GROUPS-1:0];
      end
      if (wr_opc && sys_open) begin
         mode_code_nxt = req.wdata[2:0];
      end
      if (wr_sub && sys_open) begin
         sub_power_nxt = req.wdata[0];
      end
      if (wr_rck && sys_open) begin
         clock_code_nxt   = req.wdata[2:0];
         clock_switch_nxt = req.wdata[POS_RETURN_CLOCK_SWITCH_EN];
      end
      if (wr_grp && grp_open) begin
         gw_strobe_nxt = 1'b1;
         gw_id_nxt     = req_group;
         gw_data_nxt   = {2'h0, req.wdata[DATA_W-3:0]};
      end
      // Clearing the flag and a new blocked write in the same cycle leaves it set.
      if (req.wr && req.addr == OFS_GUARD_STATUS && req.wdata[POS_STAT_BLOCKED]) begin
         blocked_nxt = 1'b0;
      end
      if (blocked_event) begin
         blocked_nxt = 1'b1;
      end
      mode_dec_nxt  = decode_mode(mode_code_nxt, alt_seen_r);
      clock_dec_nxt = decode_clock(clock_code_nxt);
   end

   // ----------------------------------------------------------------
   // Read data, valid only in the cycle after the read strobe
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = '0;
      if (req.rd) begin
         if (req.addr == OFS_WRITE_PROTECT_CONTROL) begin
            rdata_nxt[NUM_GROUPS-1:0] = unlock_r;
         end else if (req.addr == OFS_OPERATING_POWER_CONTROL) begin
            rdata_nxt[2:0] = mode_code_r;
         end else if (req.addr == OFS_SUB_POWER_CONTROL) begin
            rdata_nxt[0] = sub_power_r;
         end else if (req.addr == OFS_SLEEP_RETURN_CLOCK_SELECT) begin
            rdata_nxt[2:0]                       = clock_code_r;
            rdata_nxt[POS_RETURN_CLOCK_SWITCH_EN] = clock_switch_r;
         end else if (req.addr == OFS_GUARD_STATUS) begin
            rdata_nxt[POS_STAT_BLOCKED]       = blocked_r;
            rdata_nxt[POS_STAT_ILLEGAL_MODE]  = mode_dec_r.illegal;
            // Flags a forbidden return clock only while the switch is armed; return_clock then shows no source, only its illegal bit.
            rdata_nxt[POS_STAT_ILLEGAL_CLOCK] = clock_dec_r.illegal & clock_switch_r;
            rdata_nxt[POS_STAT_MODE +: 3]     = mode_code_r;
            rdata_nxt[POS_STAT_CLOCK +: 3]    = clock_code_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_r       <= RST_UNLOCK;
         mode_code_r    <= RST_MODE;
         sub_power_r    <= RST_SUB_POWER;
         clock_code_r   <= RST_CLOCK_SRC;
         clock_switch_r <= RST_CLOCK_SWITCH;
         blocked_r      <= 1'b0;
         alt_seen_r     <= 1'b0;
         rdata_r        <= '0;
         gw_strobe_r    <= 1'b0;
         gw_id_r        <= GRP_CLOCK;
         gw_data_r      <= '0;
         mode_dec_r     <= '0;
         clock_dec_r    <= '0;
      end else if (clk_en) begin
         unlock_r       <= unlock_nxt;
         mode_code_r    <= mode_code_nxt;
         sub_power_r    <= sub_power_nxt;
         clock_code_r   <= clock_code_nxt;
         clock_switch_r <= clock_switch_nxt;
         blocked_r      <= blocked_nxt;
         alt_seen_r     <= alt_seen_nxt;
         rdata_r        <= rdata_nxt;
         gw_strobe_r    <= gw_strobe_nxt;
         gw_id_r        <= gw_id_nxt;
         gw_data_r      <= gw_data_nxt;
         mode_dec_r     <= mode_dec_nxt;
         clock_dec_r    <= clock_dec_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata                      = rdata_r;
   assign group_write_enable         = unlock_r;
   assign group_write_strobe         = gw_strobe_r;
   assign group_write_id             = gw_id_r;
   assign group_write_data           = gw_data_r;
   assign power_mode                 = mode_dec_r;
   assign return_clock               = clock_dec_r;
   assign return_clock_switch_enable = clock_switch_r;
   assign sub_power_control          = sub_power_r;

endmodule

// file: src/pwrg_pkg.sv
// Package of constants and carrier types for the power register write guard.
package pwrg_pkg;

   // ----------------------------------------------------------------
   // Register bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_WRITE_PROTECT_CONTROL     = 8'h00;
   localparam logic [7:0] OFS_OPERATING_POWER_CONTROL   = 8'h04;
   localparam logic [7:0] OFS_SUB_POWER_CONTROL         = 8'h08;
   localparam logic [7:0] OFS_SLEEP_RETURN_CLOCK_SELECT = 8'h0C;
   localparam logic [7:0] OFS_GUARD_STATUS              = 8'h10;
   localparam logic [7:0] OFS_GROUP_WRITE_REQUEST       = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POS_CLOCK_GROUP_UNLOCK      = 0;
   localparam int POS_SYSTEM_GROUP_UNLOCK     = 1;
   localparam int POS_LOW_POWER_TIMER_UNLOCK  = 2;
   localparam int POS_VOLTAGE_DETECT_UNLOCK   = 3;
   localparam int NUM_GROUPS                  = 4;
   localparam int POS_RETURN_CLOCK_SWITCH_EN  = 7;
   localparam int POS_STAT_BLOCKED            = 0;
   localparam int POS_STAT_ILLEGAL_MODE       = 1;
   localparam int POS_STAT_ILLEGAL_CLOCK      = 2;
   localparam int POS_STAT_MODE               = 4;
   localparam int POS_STAT_CLOCK              = 8;

   // ----------------------------------------------------------------
   // Group identifiers for external protected registers
   // ----------------------------------------------------------------
   localparam logic [1:0] GRP_CLOCK   = 2'h0;
   localparam logic [1:0] GRP_SYSTEM  = 2'h1;
   localparam logic [1:0] GRP_LPTIMER = 2'h2;
   localparam logic [1:0] GRP_VDETECT = 2'h3;

   // ----------------------------------------------------------------
   // Field encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_HIGH_SPEED   = 3'h0;
   localparam logic [2:0] MODE_MIDDLE_1A    = 3'h2;
   localparam logic [2:0] MODE_MIDDLE_1B    = 3'h3;
   localparam logic [2:0] MODE_LOW_SPEED_1  = 3'h6;
   localparam logic [2:0] MODE_LOW_SPEED_2  = 3'h7;
   localparam logic [2:0] CLK_SLOW_INTERNAL = 3'h0;
   localparam logic [2:0] CLK_FAST_INTERNAL = 3'h1;
   localparam logic [2:0] CLK_MAIN_OSC      = 3'h2;

   localparam logic [3:0] RST_UNLOCK        = 4'h0;
   localparam logic [2:0] RST_MODE          = 3'h0;
   localparam logic [2:0] RST_ALT_MODE      = 3'h2;
   localparam logic       RST_SUB_POWER     = 1'b0;
   localparam logic [2:0] RST_CLOCK_SRC     = 3'h0;
   localparam logic       RST_CLOCK_SWITCH  = 1'b0;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } pwrg_req_t;

   typedef struct packed {
      logic high_speed;
      logic middle_1a;
      logic middle_1b;
      logic low_speed_1;
      logic low_speed_2;
      logic illegal;
   } pwrg_mode_t;

   typedef struct packed {
      logic slow_internal;
      logic fast_internal;
      logic main_osc;
      logic illegal;
   } pwrg_clk_t;

endpackage

// file: tb/pwrg_guard_properties.sv
// Port-level assertion checker for the power register write guard.
`timescale 1ns/1ps
module pwrg_guard_checker
   import pwrg_pkg::*;
(
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   input wire logic                  clk_en,
   input wire logic                  alt_variant,
   input wire pwrg_req_t             req,
   input wire logic [DATA_W-1:0]     rdata,
   input wire logic [NUM_GROUPS-1:0] group_write_enable,
   input wire logic                  group_write_strobe,
   input wire logic [1:0]            group_write_id,
   input wire logic [DATA_W-1:0]     group_write_data,
   input wire pwrg_mode_t            power_mode,
   input wire pwrg_clk_t             return_clock,
   input wire logic                  return_clock_switch_enable,
   input wire logic                  sub_power_control
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   logic wr_ok;
   logic rd_ok;
   logic fwd_req;
   logic alt_q;
   assign wr_ok   = clk_en && req.wr;
   assign rd_ok   = clk_en && req.rd;
   assign fwd_req = wr_ok && req.addr == OFS_GROUP_WRITE_REQUEST;
   // The variant select passes a flop first, so decode follows it one cycle late.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alt_q <= 1'b0;
      end else if (clk_en) begin
         alt_q <= alt_variant;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_unlock_write: assert property (wr_ok && req.addr == OFS_WRITE_PROTECT_CONTROL
      |=> group_write_enable == $past(req.wdata[3:0])) else $error("unlock bits not taken");
   a_group_forward: assert property (fwd_req && group_write_enable[req.wdata[15:14]]
      |=> group_write_strobe && group_write_id == $past(req.wdata[15:14])
          && group_write_data == {2'h0, $past(req.wdata[13:0])}) else $error("open group write not forwarded");
   a_locked_drop: assert property (fwd_req && !group_write_enable[req.wdata[15:14]]
      |=> !group_write_strobe) else $error("locked group write forwarded");
   a_strobe_cause: assert property ($rose(group_write_strobe) |-> $past(fwd_req))
      else $error("forward strobe without request");
   a_sub_locked: assert property (wr_ok && req.addr == OFS_SUB_POWER_CONTROL
      && !group_write_enable[POS_SYSTEM_GROUP_UNLOCK] |=> $stable(sub_power_control))
      else $error("locked sub power write took effect");
   a_read_unlock: assert property (rd_ok && req.addr == OFS_WRITE_PROTECT_CONTROL
      |=> rdata[3:0] == group_write_enable) else $error("unlock readback wrong");
   a_clock_decode: assert property (rd_ok && req.addr == OFS_SLEEP_RETURN_CLOCK_SELECT
      |=> return_clock.slow_internal == (rdata[2:0] == CLK_SLOW_INTERNAL)
          && return_clock.fast_internal == (rdata[2:0] == CLK_FAST_INTERNAL)
          && return_clock.main_osc == (rdata[2:0] == CLK_MAIN_OSC)
          && return_clock_switch_enable == rdata[POS_RETURN_CLOCK_SWITCH_EN]) else $error("clock decode wrong");
   a_mode_decode: assert property (rd_ok && req.addr == OFS_OPERATING_POWER_CONTROL && !alt_q
      |=> power_mode.high_speed == (rdata[2:0] == MODE_HIGH_SPEED)
          && power_mode.middle_1a == (rdata[2:0] == MODE_MIDDLE_1A)) else $error("mode decode wrong");
   a_alt_decode: assert property (rd_ok && req.addr == OFS_OPERATING_POWER_CONTROL && alt_q
      |=> power_mode.middle_1a == (rdata[2:0] == MODE_MIDDLE_1A)
          && power_mode.middle_1b == (rdata[2:0] == MODE_MIDDLE_1B)
          && power_mode.low_speed_1 == (rdata[2:0] == MODE_LOW_SPEED_1)
          && power_mode.low_speed_2 == (rdata[2:0] == MODE_LOW_SPEED_2)) else $error("alt mode decode wrong");
   c_forward: cover property (fwd_req && group_write_enable[req.wdata[15:14]]);
   c_alt_read: cover property (rd_ok && req.addr == OFS_OPERATING_POWER_CONTROL && alt_q);
   c_locked: cover property (wr_ok && req.addr == OFS_SUB_POWER_CONTROL && !group_write_enable[1]);
endmodule

bind pwrg_guard pwrg_guard_checker i_chk (.core_clk, .rst_n, .clk_en, .alt_variant, .req, .rdata,
   .group_write_enable, .group_write_strobe, .group_write_id, .group_write_data, .power_mode,
   .return_clock, .return_clock_switch_enable, .sub_power_control);

// file: tb/test_pwrg_guard.sv
// Self-checking bench for the power register write guard.
`timescale 1ns/1ps
module test_pwrg_guard
   import pwrg_pkg::*;
;
   typedef struct packed {
      logic        alt;
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [5:0]  mode;
      logic [3:0]  clk;
   } pwrg_row_t;
   logic                  core_clk;
   logic                  rst_n;
   logic                  clk_en;
   logic                  alt_variant;
   pwrg_req_t             req;
   logic [DATA_W-1:0]     rdata;
   logic [NUM_GROUPS-1:0] group_write_enable;
   logic                  group_write_strobe;
   logic [1:0]            group_write_id;
   logic [DATA_W-1:0]     group_write_data;
   pwrg_mode_t            power_mode;
   pwrg_clk_t             return_clock;
   logic                  return_clock_switch_enable;
   logic                  sub_power_control;
   logic [15:0]           v;
   int                    num_errors;
   int                    checked;
   // Undefined return codes are never written with the switch enabled.
   pwrg_row_t rows [10] = '{
      '{1'b0, 8'h0C, 16'h0001, 6'h20, 4'h4}, '{1'b0, 8'h0C, 16'h0002, 6'h20, 4'h2},
      '{1'b0, 8'h0C, 16'h0081, 6'h20, 4'h4}, '{1'b0, 8'h0C, 16'h0080, 6'h20, 4'h8},
      '{1'b0, 8'h04, 16'h0002, 6'h10, 4'h8}, '{1'b0, 8'h04, 16'h0005, 6'h01, 4'h8},
      '{1'b1, 8'h04, 16'h0002, 6'h10, 4'h8}, '{1'b1, 8'h04, 16'h0003, 6'h08, 4'h8},
      '{1'b1, 8'h04, 16'h0006, 6'h04, 4'h8}, '{1'b1, 8'h04, 16'h0007, 6'h02, 4'h8}};

   pwrg_guard i_dut (.core_clk, .rst_n, .clk_en, .alt_variant, .req, .rdata, .group_write_enable,
      .group_write_strobe, .group_write_id, .group_write_data, .power_mode, .return_clock,
      .return_clock_switch_enable, .sub_power_control);

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk);
      req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic print_verdict;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      num_errors++;
      print_verdict;
   end
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      alt_variant = 1'b0;
      req = '0;
      num_errors = 0;
      checked = 0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      wr(OFS_WRITE_PROTECT_CONTROL, 16'h0002);
      foreach (rows[i]) begin
         @(posedge core_clk);
         alt_variant <= rows[i].alt;
         wr(rows[i].addr, rows[i].wdata);
         check({10'h0, power_mode}, {10'h0, rows[i].mode});
         check({12'h0, return_clock}, {12'h0, rows[i].clk});
         rd(rows[i].addr, v);
         check(v, rows[i].wdata);
      end
      wr(OFS_SUB_POWER_CONTROL, 16'h0001);
      check({15'h0, sub_power_control}, 16'h0001);
      wr(OFS_WRITE_PROTECT_CONTROL, 16'h0000);
      wr(OFS_SUB_POWER_CONTROL, 16'h0000);
      check({15'h0, sub_power_control}, 16'h0001);
      wr(OFS_OPERATING_POWER_CONTROL, 16'h0002);
      rd(OFS_OPERATING_POWER_CONTROL, v);
      check(v, 16'h0007);
      rd(OFS_GUARD_STATUS, v);
      check({15'h0, v[POS_STAT_BLOCKED]}, 16'h0001);
      check(v, {5'h0, CLK_SLOW_INTERNAL, 1'h0, MODE_LOW_SPEED_2, 4'h1});
      check({15'h0, return_clock_switch_enable}, 16'h0001);
      wr(OFS_GUARD_STATUS, 16'h0001);
      rd(OFS_GUARD_STATUS, v);
      check({15'h0, v[POS_STAT_BLOCKED]}, 16'h0000);
      for (int g = 0; g < NUM_GROUPS; g++) begin
         wr(OFS_WRITE_PROTECT_CONTROL, 16'h1 << g);
         check({12'h0, group_write_enable}, 16'h1 << g);
         rd(OFS_WRITE_PROTECT_CONTROL, v);
         check(v, 16'h1 << g);
         wr(OFS_GROUP_WRITE_REQUEST, {g[1:0], 14'h1A5C});
         check({13'h0, group_write_strobe, group_write_id}, {13'h0, 1'b1, g[1:0]});
         check(group_write_data, 16'h1A5C);
         wr(OFS_GROUP_WRITE_REQUEST, {g[1:0] + 2'h1, 14'h3FFF});
         check({15'h0, group_write_strobe}, 16'h0000);
      end
      // A frozen clock enable must hold the unlock bits against a write.
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(OFS_WRITE_PROTECT_CONTROL, 16'h000F);
      check({12'h0, group_write_enable}, 16'h0008);
      @(posedge core_clk);
      clk_en <= 1'b1;
      wr(8'h20, 16'hFFFF);
      rd(8'h20, v);
      check(v, 16'h0000);
      @(posedge core_clk);
      rst_n <= 1'b0;
      #1;
      check({group_write_enable, 4'h0, power_mode, sub_power_control, group_write_strobe}, 16'h0);
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      wr(OFS_SUB_POWER_CONTROL, 16'h0001);
      check({15'h0, sub_power_control}, 16'h0000);
      print_verdict;
   end
endmodule
